//--- rtl/char_port.sv
// host parallel port of the character display controller
//
// What this block does
// - register select high reaches transfer register, low reaches command register.
// - read/write high means module drives data bus; low means host writes.
// - controller holds an 8-bit command register and an 8-bit transfer register.
// - command register is loaded only by host writes and never read back.
// - writing an address instruction fetches the addressed byte into transfer register.
// - select 0, write: byte taken as instruction and its operation started.
// - select 0, read: busy flag on bit 7, ram pointer on the rest.
// - select 1, write: byte goes straight into last addressed ram and into transfer register.
// - select 1, read: transfer register byte from text or glyph ram driven out.
// - while busy the controller refuses any further instruction.
// - one ram pointer addresses both rams; last address, home or clear instruction picks which.
// - text ram holds 80 eight-bit character codes.
// - visible positions 1 to 8 show text ram addresses 00 to 07.
// - glyph rom turns each code with upper nibble nonzero into a 5x8 or 5x10 dot pattern.
// - glyph ram is writable: eight 5x8 or four 5x10 user patterns.
// - codes with upper nibble zero pick a user glyph, bit 3 ignored.
// - set text address has bit 7 high, 7-bit address, takes 39 us.
// - set glyph address has bits 7..6 = 01, 6-bit address, 39 us.
// - function set picks bus width, line count and font height, 39 us.
// - data write stores at ram pointer and keeps device busy 43 us.
`timescale 1ns/1ps
`default_nettype none
module char_port
  import char_port_pkg::*;
#(
  parameter int LONG_CYC = LONG_OP_CYC
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // host pins
  input  wire logic              register_select,
  input  wire logic              read_write,
  input  wire logic              strobe,
  input  wire logic [DATA_W-1:0] db_in,
  output var  logic [DATA_W-1:0] db_out,
  output var  logic              db_oe,
  // display scan, same clock domain
  input  wire logic [2:0]        scan_pos,
  input  wire logic [3:0]        scan_row,
  output var  logic [4:0]        glyph_dots,
  output var  logic              display_on
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int SYNC_W = DATA_W + 3;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic              e_prev_q;
  logic              rs_s;
  logic              rw_s;
  logic              e_s;
  logic [DATA_W-1:0] db_s;
  logic              e_rise;
  logic              e_fall;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q  <= '0;
      sync2_q  <= '0;
      e_prev_q <= 1'b0;
    end else begin
      sync1_q  <= {register_select, read_write, strobe, db_in};
      sync2_q  <= sync1_q;
      e_prev_q <= e_s;
    end
  end

  assign {rs_s, rw_s, e_s, db_s} = sync2_q;
  assign e_rise = e_s && !e_prev_q;
  assign e_fall = !e_s && e_prev_q;

  //////////////////////////////////////////////////////////////////////////////
  // controller state
  mem_bus_if mb ();

  char_mem u_mem (
    .ref_clk (ref_clk),
    .mb      (mb.mem)
  );

  ctrl_state_t       state_q, state_d;
  logic [DATA_W-1:0] command_q, command_d;
  logic [DATA_W-1:0] transfer_q, transfer_d;
  logic [PTR_W-1:0]  ptr_q, ptr_d;
  logic [PTR_W-1:0]  clr_q, clr_d;
  logic [BUSY_W-1:0] busy_q, busy_d;
  logic [1:0]        fetch_q, fetch_d;
  logic              glyph_sel_q, glyph_sel_d;
  logic              wide_q, wide_d;
  logic              two_line_q, two_line_d;
  logic              tall_q, tall_d;
  logic              inc_q, inc_d;
  logic              disp_shift_q, disp_shift_d;
  logic              on_q, on_d;
  logic              cursor_q, cursor_d;
  logic              blink_q, blink_d;
  logic              nib_q, nib_d;
  logic [3:0]        hold_q, hold_d;
  logic [DATA_W-1:0] db_out_d;
  logic              db_oe_d;
  logic [4:0]        dots_q, dots_d;
  logic              busy;
  logic [DATA_W-1:0] byte_in;
  logic [DATA_W-1:0] rd_val;
  logic              last_nib;

  function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p, input logic up,
                                             input logic glyph);
    logic [PTR_W-1:0] n;
    n = up ? PTR_W'(p + 1'b1) : PTR_W'(p - 1'b1);
    if (glyph) begin
      n[PTR_W-1] = 1'b0;
    end else if (up && p == TEXT_LAST) begin
      n = '0;
    end else if (!up && p == '0) begin
      n = TEXT_LAST;
    end
    step = n;
  endfunction : step

  assign busy     = (busy_q != '0) || (state_q == ST_CLEAR);
  assign last_nib = wide_q || nib_q;
  assign byte_in  = wide_q ? db_s : {hold_q, db_s[DATA_W-1:4]};
  assign rd_val   = rs_s ? transfer_q : {busy, ptr_q};

  always_comb begin
    state_d      = state_q;
    command_d    = command_q;
    transfer_d   = transfer_q;
    ptr_d        = ptr_q;
    clr_d        = clr_q;
    busy_d       = (busy_q != '0) ? BUSY_W'(busy_q - 1'b1) : busy_q;
    fetch_d      = {fetch_q[0], 1'b0};
    glyph_sel_d  = glyph_sel_q;
    wide_d       = wide_q;
    two_line_d   = two_line_q;
    tall_d       = tall_q;
    inc_d        = inc_q;
    disp_shift_d = disp_shift_q;
    on_d         = on_q;
    cursor_d     = cursor_q;
    blink_d      = blink_q;
    nib_d        = nib_q;
    hold_d       = hold_q;
    db_out_d     = db_out;
    db_oe_d      = db_oe;
    mb.wr_en     = 1'b0;
    mb.wr_glyph  = glyph_sel_q;
    mb.wr_addr   = ptr_q;
    mb.wr_data   = transfer_q;

    // fetched byte lands two cycles after the pointer settles
    if (fetch_q[1]) begin
      transfer_d = mb.rd_data;
    end

    // read data appears three cycles after the strobe rises; a slow host
    // strobe is assumed, the pin-to-pin delay is not met at this clock
    if (e_rise && rw_s) begin
      db_oe_d  = 1'b1;
      db_out_d = rd_val;
      if (!wide_q) begin
        db_out_d = nib_q ? {rd_val[3:0], 4'h0} : {rd_val[DATA_W-1:4], 4'h0};
      end
    end
    if (e_fall) begin
      db_oe_d = 1'b0;
    end

    case (state_q)
      ST_CLEAR: begin
        mb.wr_en    = 1'b1;
        mb.wr_glyph = 1'b0;
        mb.wr_addr  = clr_q;
        mb.wr_data  = CLEAR_FILL;
        clr_d       = PTR_W'(clr_q + 1'b1);
        if (clr_q == TEXT_LAST) begin
          state_d   = ST_RUN;
          fetch_d   = 2'b01;
        end
      end
      ST_RUN: begin
        if (e_fall) begin
          if (!last_nib) begin
            hold_d = db_s[DATA_W-1:4];
            nib_d  = 1'b1;
          end else begin
            nib_d = 1'b0;
            if (!rs_s && !rw_s && !busy) begin
              command_d = byte_in;
              busy_d    = BUSY_W'(SHORT_OP_CYC);
              if (byte_in[OP_TEXT_ADDR]) begin
                ptr_d       = byte_in[PTR_W-1:0];
                glyph_sel_d = 1'b0;
                fetch_d     = 2'b01;
              end else if (byte_in[OP_GLYPH_ADDR]) begin
                ptr_d       = {1'b0, byte_in[GLYPH_AW-1:0]};
                glyph_sel_d = 1'b1;
                fetch_d     = 2'b01;
              end else if (byte_in[OP_FUNC]) begin
                wide_d     = byte_in[FS_WIDTH_BIT];
                two_line_d = byte_in[FS_LINES_BIT];
                tall_d     = byte_in[FS_FONT_BIT];
              end else if (byte_in[OP_SHIFT]) begin
                if (!byte_in[SH_DISP_BIT]) begin
                  ptr_d = step(ptr_q, byte_in[SH_RIGHT_BIT], glyph_sel_q);
                end
              end else if (byte_in[OP_DISPLAY]) begin
                on_d     = byte_in[DC_ON_BIT];
                cursor_d = byte_in[DC_CURSOR_BIT];
                blink_d  = byte_in[DC_BLINK_BIT];
              end else if (byte_in[OP_ENTRY]) begin
                inc_d        = byte_in[EM_INC_BIT];
                disp_shift_d = byte_in[EM_SHIFT_BIT];
              end else if (byte_in[OP_HOME]) begin
                ptr_d       = '0;
                glyph_sel_d = 1'b0;
                busy_d      = BUSY_W'(LONG_CYC);
                fetch_d     = 2'b01;
              end else if (byte_in[OP_CLEAR]) begin
                state_d     = ST_CLEAR;
                clr_d       = '0;
                ptr_d       = '0;
                glyph_sel_d = 1'b0;
                inc_d       = 1'b1;
                busy_d      = BUSY_W'(LONG_CYC);
              end
            end else if (rs_s && !rw_s && !busy) begin
              mb.wr_en   = 1'b1;
              mb.wr_data = byte_in;
              transfer_d = byte_in;
              ptr_d      = step(ptr_q, inc_q, glyph_sel_q);
              busy_d     = BUSY_W'(DATA_OP_CYC);
              fetch_d    = 2'b01;
            end else if (rs_s && rw_s && !busy) begin
              ptr_d   = step(ptr_q, inc_q, glyph_sel_q);
              busy_d  = BUSY_W'(DATA_OP_CYC);
              fetch_d = 2'b01;
            end
          end
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase

    dots_d = on_q ? mb.scan_dots : 5'h00;
  end

  assign mb.rd_glyph  = glyph_sel_q;
  assign mb.rd_addr   = ptr_q;
  assign mb.scan_pos  = scan_pos;
  assign mb.scan_row  = scan_row;
  assign mb.tall_font = tall_q;

  //////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q      <= ST_RUN;
      command_q    <= '0;
      transfer_q   <= '0;
      ptr_q        <= '0;
      clr_q        <= '0;
      busy_q       <= '0;
      fetch_q      <= '0;
      glyph_sel_q  <= 1'b0;
      wide_q       <= 1'b1;
      two_line_q   <= 1'b0;
      tall_q       <= 1'b0;
      inc_q        <= 1'b1;
      disp_shift_q <= 1'b0;
      on_q         <= 1'b0;
      cursor_q     <= 1'b0;
      blink_q      <= 1'b0;
      nib_q        <= 1'b0;
      hold_q       <= '0;
      db_out       <= '0;
      db_oe        <= 1'b0;
      dots_q       <= '0;
    end else begin
      state_q      <= state_d;
      command_q    <= command_d;
      transfer_q   <= transfer_d;
      ptr_q        <= ptr_d;
      clr_q        <= clr_d;
      busy_q       <= busy_d;
      fetch_q      <= fetch_d;
      glyph_sel_q  <= glyph_sel_d;
      wide_q       <= wide_d;
      two_line_q   <= two_line_d;
      tall_q       <= tall_d;
      inc_q        <= inc_d;
      disp_shift_q <= disp_shift_d;
      on_q         <= on_d;
      cursor_q     <= cursor_d;
      blink_q      <= blink_d;
      nib_q        <= nib_d;
      hold_q       <= hold_d;
      db_out       <= db_out_d;
      db_oe        <= db_oe_d;
      dots_q       <= dots_d;
    end
  end

  assign glyph_dots = dots_q;
  assign display_on = on_q;

endmodule : char_port
`default_nettype wire

//--- rtl/char_port_pkg.sv
// constants shared by the character display host port and its memories
package char_port_pkg;

  // widths and memory sizes
  localparam int DATA_W      = 8;
  localparam int PTR_W       = 7;
  localparam int GLYPH_AW    = 6;
  localparam int TEXT_DEPTH  = 80;
  localparam int GLYPH_DEPTH = 64;
  localparam int VISIBLE     = 8;
  localparam logic [PTR_W-1:0] TEXT_LAST = 7'h4F;
  localparam logic [DATA_W-1:0] CLEAR_FILL = 8'h00;

  // execution times and their cycle counts at the 10 MHz clock
  localparam int CLK_MHZ       = 10;
  localparam int T_SHORT_NS    = 39000;
  localparam int T_DATA_NS     = 43000;
  localparam int T_LONG_NS     = 1530000;
  localparam int SHORT_OP_CYC  = (T_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int DATA_OP_CYC   = (T_DATA_NS * CLK_MHZ + 999) / 1000;
  localparam int LONG_OP_CYC   = (T_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int BUSY_W        = 15;

  // instruction opcode marker bits, highest set bit decides
  localparam int OP_TEXT_ADDR  = 7;
  localparam int OP_GLYPH_ADDR = 6;
  localparam int OP_FUNC       = 5;
  localparam int OP_SHIFT      = 4;
  localparam int OP_DISPLAY    = 3;
  localparam int OP_ENTRY      = 2;
  localparam int OP_HOME       = 1;
  localparam int OP_CLEAR      = 0;

  // operand field positions
  localparam int FS_WIDTH_BIT  = 4;
  localparam int FS_LINES_BIT  = 3;
  localparam int FS_FONT_BIT   = 2;
  localparam int EM_INC_BIT    = 1;
  localparam int EM_SHIFT_BIT  = 0;
  localparam int DC_ON_BIT     = 2;
  localparam int DC_CURSOR_BIT = 1;
  localparam int DC_BLINK_BIT  = 0;
  localparam int SH_DISP_BIT   = 3;
  localparam int SH_RIGHT_BIT  = 2;
  localparam int BUSY_BIT      = 7;

  typedef enum logic {ST_RUN, ST_CLEAR} ctrl_state_t;

endpackage : char_port_pkg

//--- rtl/mem_bus_if.sv
// link between the port controller and its text, glyph memories and scan path
`timescale 1ns/1ps
`default_nettype none
interface mem_bus_if;
  import char_port_pkg::*;
  logic                wr_en;
  logic                wr_glyph;
  logic [PTR_W-1:0]    wr_addr;
  logic [DATA_W-1:0]   wr_data;
  logic                rd_glyph;
  logic [PTR_W-1:0]    rd_addr;
  logic [DATA_W-1:0]   rd_data;
  logic [2:0]          scan_pos;
  logic [3:0]          scan_row;
  logic                tall_font;
  logic [4:0]          scan_dots;

  modport ctrl (output wr_en, wr_glyph, wr_addr, wr_data, rd_glyph, rd_addr,
                scan_pos, scan_row, tall_font, input rd_data, scan_dots);
  modport mem  (input wr_en, wr_glyph, wr_addr, wr_data, rd_glyph, rd_addr,
                scan_pos, scan_row, tall_font, output rd_data, scan_dots);
endinterface : mem_bus_if
`default_nettype wire

//--- rtl/char_mem.sv
// text ram, glyph ram, stand-in glyph rom and the dot scan path
`timescale 1ns/1ps
`default_nettype none
module char_mem
  import char_port_pkg::*;
(
  // clock
  input  wire logic ref_clk,
  // controller side
  mem_bus_if.mem    mb
);

  logic [DATA_W-1:0] text_ram  [TEXT_DEPTH];
  logic [DATA_W-1:0] glyph_ram [GLYPH_DEPTH];
  logic [DATA_W-1:0] rd_q;
  logic [DATA_W-1:0] code_q;
  logic [3:0]        row_q;
  logic [4:0]        dots_q;
  logic [DATA_W-1:0] code_d;
  logic [4:0]        dots_d;
  logic [GLYPH_AW-1:0] uaddr;

  // stand-in font: the real artwork lives in a mask rom outside this model
  function automatic logic [4:0] rom_dots(input logic [7:0] code, input logic [3:0] row);
    rom_dots = code[4:0] ^ {row, row[0]};
  endfunction : rom_dots

  always_comb begin
    code_d = text_ram[mb.scan_pos];
    // user codes: upper nibble zero, bit 3 ignored, row forms low address
    if (mb.tall_font) begin
      uaddr = {code_q[2:1], row_q};
    end else begin
      uaddr = {code_q[2:0], row_q[2:0]};
    end
    if (code_q[7:4] == 4'h0) begin
      dots_d = glyph_ram[uaddr][4:0];
    end else begin
      dots_d = rom_dots(code_q, row_q);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (mb.wr_en && mb.wr_glyph) begin
      glyph_ram[mb.wr_addr[GLYPH_AW-1:0]] <= mb.wr_data;
    end
    if (mb.wr_en && !mb.wr_glyph) begin
      text_ram[mb.wr_addr] <= mb.wr_data;
    end
    rd_q   <= mb.rd_glyph ? glyph_ram[mb.rd_addr[GLYPH_AW-1:0]]
                          : text_ram[mb.rd_addr];
    code_q <= code_d;
    row_q  <= mb.scan_row;
    dots_q <= dots_d;
  end

  assign mb.rd_data   = rd_q;
  assign mb.scan_dots = dots_q;

endmodule : char_mem
`default_nettype wire

//--- verif/char_port_properties.sv
// pin-level assertions for the character display host port
`timescale 1ns/1ps
`default_nettype none
module char_port_properties
  import char_port_pkg::*;
#(
  parameter int LONG_CYC = LONG_OP_CYC
) (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              reset_n,
  // host pins
  input wire logic              register_select,
  input wire logic              read_write,
  input wire logic              strobe,
  input wire logic [DATA_W-1:0] db_in,
  input wire logic [DATA_W-1:0] db_out,
  input wire logic              db_oe,
  // display scan
  input wire logic [2:0]        scan_pos,
  input wire logic [3:0]        scan_row,
  input wire logic [4:0]        glyph_dots,
  input wire logic              display_on
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  sequence read_start;
    $rose(strobe) && read_write;
  endsequence
  sequence read_end;
    $fell(strobe) && db_oe;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_read_drive: assert property (read_start |-> ##[2:4] db_oe)
    else $error("bus not driven after read strobe");
  a_read_holds: assert property (db_oe && strobe |=> db_oe)
    else $error("bus released while strobe high");
  a_read_release: assert property (read_end |-> ##[2:4] !db_oe)
    else $error("bus not released after strobe fall");
  a_idle_quiet: assert property ((!strobe)[*5] |-> !db_oe)
    else $error("bus driven without strobe");
  a_write_quiet: assert property ((!read_write)[*5] |-> !db_oe)
    else $error("bus driven during write");
  a_drive_cause: assert property ($rose(db_oe) |-> $past(read_write, 2) && $past(strobe, 2))
    else $error("bus drive without read request");
  a_dark_display: assert property ((!display_on)[*4] |-> glyph_dots == 5'h00)
    else $error("dots shown while display off");
  a_data_steady: assert property (register_select && $past(register_select, 4) && db_oe
                                  && $past(db_oe) |-> $stable(db_out))
    else $error("read data changed while driven");
endmodule : char_port_properties

bind char_port char_port_properties #(.LONG_CYC(LONG_CYC)) i_props (
  .ref_clk(ref_clk), .reset_n(reset_n), .register_select(register_select),
  .read_write(read_write), .strobe(strobe), .db_in(db_in), .db_out(db_out),
  .db_oe(db_oe), .scan_pos(scan_pos), .scan_row(scan_row),
  .glyph_dots(glyph_dots), .display_on(display_on)
);
`default_nettype wire

//--- verif/host_model.sv
// host processor model driving the parallel pins of the character port
`timescale 1ns/1ps
`default_nettype none
module host_model
  import char_port_pkg::*;
(
  // clock
  input  wire logic              ref_clk,
  // host pins
  output var  logic              register_select,
  output var  logic              read_write,
  output var  logic              strobe,
  output var  logic [DATA_W-1:0] db_in,
  input  wire logic [DATA_W-1:0] db_out
);
  logic narrow;
  logic stuck;

  initial begin
    narrow          = 1'b0;
    stuck           = 1'b0;
    register_select = 1'b0;
    read_write      = 1'b1;
    strobe          = 1'b0;
    db_in           = 8'hA5;
  end

  ////////////////////////////////////////////////////////////////////////////
  // slow pulses on purpose: the pins pass two synchroniser flops
  task automatic pulse(input logic rs, input logic rw, input logic [7:0] wd,
                       output logic [7:0] rd);
    @(posedge ref_clk);
    #10;
    register_select = rs;
    read_write      = rw;
    db_in           = rw ? ~db_in : wd;
    strobe          = 1'b1;
    repeat (6) @(posedge ref_clk);
    #10;
    rd     = db_out;
    strobe = 1'b0;
    repeat (6) @(posedge ref_clk);
    #10;
    // undriven bus shows no stale value
    db_in = ~db_in;
  endtask : pulse

  task automatic xfer(input logic rs, input logic rw, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [7:0] hi;
    logic [7:0] lo;
    if (narrow) begin
      pulse(rs, rw, {wd[7:4], 4'h0}, hi);
      pulse(rs, rw, {wd[3:0], 4'h0}, lo);
      rd = {hi[7:4], lo[7:4]};
    end else begin
      pulse(rs, rw, wd, rd);
    end
  endtask : xfer

  task automatic wait_ready(output logic ok);
    logic [7:0] st;
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      xfer(1'b0, 1'b1, 8'h00, st);
      ok = (st[BUSY_BIT] === 1'b0);
    end
    // sticky so that an unchecked wait that never clears still fails the run
    if (!ok) begin
      stuck = 1'b1;
    end
  endtask : wait_ready
endmodule : host_model
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the character display host port
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import char_port_pkg::*;
;
  logic              ref_clk;
  logic              reset_n;
  logic              register_select;
  logic              read_write;
  logic              strobe;
  logic [DATA_W-1:0] db_in;
  logic [DATA_W-1:0] db_out;
  logic              db_oe;
  logic [2:0]        scan_pos;
  logic [3:0]        scan_row;
  logic [4:0]        glyph_dots;
  logic              display_on;
  logic [7:0]        rd;
  logic              ok;
  int                n_fail = 0;
  int                check_count = 0;
  int                cyc = 0;
  int                t0;

`define check_eq(got, exp, msg) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp); \
    end \
  end

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////
  // long operations shortened so clear and home stay cheap
  char_port #(.LONG_CYC(500)) i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .register_select(register_select),
    .read_write(read_write), .strobe(strobe), .db_in(db_in), .db_out(db_out),
    .db_oe(db_oe), .scan_pos(scan_pos), .scan_row(scan_row),
    .glyph_dots(glyph_dots), .display_on(display_on)
  );
  host_model i_host (
    .ref_clk(ref_clk), .register_select(register_select), .read_write(read_write),
    .strobe(strobe), .db_in(db_in), .db_out(db_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmd(input logic [7:0] c);
    i_host.xfer(1'b0, 1'b0, c, rd);
    i_host.wait_ready(ok);
    `check_eq(ok, 1'b1, "ready after command");
  endtask : cmd

  task automatic status(input logic [7:0] exp);
    i_host.xfer(1'b0, 1'b1, 8'h00, rd);
    `check_eq(rd, exp, "status");
  endtask : status

  task automatic test_text;
    status(8'h00);
    i_host.xfer(1'b0, 1'b0, 8'h85, rd);
    status(8'h85);
    i_host.wait_ready(ok);
    i_host.xfer(1'b1, 1'b0, 8'hA5, rd);
    i_host.wait_ready(ok);
    status(8'h06);
    cmd(8'h85);
    i_host.xfer(1'b1, 1'b1, 8'h00, rd);
    `check_eq(rd, 8'hA5, "text readback");
    i_host.wait_ready(ok);
    status(8'h06);
    cmd(8'hCF);
    i_host.xfer(1'b1, 1'b0, 8'h77, rd);
    i_host.wait_ready(ok);
    status(8'h00);
    $display("test_text done");
  endtask : test_text

  task automatic test_busy;
    cmd(8'h81);
    i_host.xfer(1'b1, 1'b0, 8'h33, rd);
    i_host.wait_ready(ok);
    cmd(8'h80);
    i_host.xfer(1'b1, 1'b0, 8'h11, rd);
    t0 = cyc;
    // both of these land while busy and must be dropped
    i_host.xfer(1'b1, 1'b0, 8'h22, rd);
    i_host.xfer(1'b0, 1'b0, 8'h90, rd);
    i_host.wait_ready(ok);
    `check_eq(cyc - t0 >= DATA_OP_CYC - 10 && cyc - t0 <= DATA_OP_CYC + 30, 1'b1, "busy span");
    status(8'h01);
    cmd(8'h81);
    i_host.xfer(1'b1, 1'b1, 8'h00, rd);
    `check_eq(rd, 8'h33, "refused write kept out");
    i_host.wait_ready(ok);
    $display("test_busy done");
  endtask : test_busy

  task automatic test_glyph;
    cmd(8'h48);
    i_host.xfer(1'b1, 1'b0, 8'h1F, rd);
    i_host.wait_ready(ok);
    status(8'h09);
    cmd(8'h80);
    i_host.xfer(1'b1, 1'b0, 8'h01, rd);
    i_host.wait_ready(ok);
    i_host.xfer(1'b1, 1'b0, 8'h09, rd);
    i_host.wait_ready(ok);
    cmd(8'h0C);
    `check_eq(display_on, 1'b1, "display on");
    for (int p = 0; p < 2; p++) begin
      @(posedge ref_clk);
      #10;
      scan_pos = p[2:0];
      scan_row = 4'h0;
      repeat (4) @(posedge ref_clk);
      #10;
      `check_eq(glyph_dots, 5'h1F, "user glyph dots");
    end
    cmd(8'h08);
    `check_eq(glyph_dots, 5'h00, "display off dots");
    $display("test_glyph done");
  endtask : test_glyph

  task automatic test_narrow;
    i_host.xfer(1'b0, 1'b0, 8'h20, rd);
    i_host.narrow = 1'b1;
    i_host.wait_ready(ok);
    cmd(8'h93);
    status(8'h13);
    i_host.xfer(1'b1, 1'b0, 8'h5A, rd);
    i_host.wait_ready(ok);
    cmd(8'h93);
    i_host.xfer(1'b1, 1'b1, 8'h00, rd);
    `check_eq(rd, 8'h5A, "narrow readback");
    i_host.wait_ready(ok);
    i_host.xfer(1'b0, 1'b0, 8'h30, rd);
    i_host.narrow = 1'b0;
    i_host.wait_ready(ok);
    status(8'h14);
    $display("test_narrow done");
  endtask : test_narrow

  task automatic test_modes;
    cmd(8'h85);
    cmd(8'h04);
    i_host.xfer(1'b1, 1'b0, 8'h3C, rd);
    i_host.wait_ready(ok);
    status(8'h04);
    cmd(8'h14);
    status(8'h05);
    i_host.xfer(1'b0, 1'b0, 8'h02, rd);
    status(8'h80);
    i_host.wait_ready(ok);
    cmd(8'h01);
    cmd(8'h85);
    i_host.xfer(1'b1, 1'b1, 8'h00, rd);
    `check_eq(rd, 8'h00, "cleared text");
    i_host.wait_ready(ok);
    status(8'h06);
    $display("test_modes done");
  endtask : test_modes

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    `check_eq(i_host.stuck, 1'b0, "busy poll limit");
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    reset_n  = 1'b0;
    scan_pos = 3'h0;
    scan_row = 4'h0;
    repeat (16) @(posedge ref_clk);
    #10;
    `check_eq({db_oe, display_on, glyph_dots}, 7'h00, "reset outputs");
    reset_n = 1'b1;
    test_text();
    test_busy();
    test_glyph();
    test_narrow();
    test_modes();
    final_report();
  end

  // about 15k cycles expected; the watchdog cuts the run off at 80k cycles
  initial begin
    #8000000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
